// [dwid_pkg.sv]
// package of constants for the dual wiper two-wire write decoder
package dwid_pkg;
   localparam logic [3:0] DWID_ADDR_HI      = 4'h5;  // fixed upper address bits
   localparam logic [7:0] DWID_CMD_REG_A    = 8'h11; // load wiper a
   localparam logic [7:0] DWID_CMD_REG_B    = 8'h12; // load wiper b
   localparam logic [7:0] DWID_CMD_REG_AB   = 8'h13; // load both wipers
   localparam logic [7:0] DWID_WIPER_RESET  = 8'h80; // midscale after power-on
   localparam logic [3:0] DWID_ACK_BIT      = 4'h8;  // bit index of ack slot
   localparam logic [3:0] DWID_LAST_DATA    = 4'h7;  // last data bit index
   // byte-level states of one write frame
   typedef enum logic [2:0] {
      DWID_IDLE = 3'b000,
      DWID_ADDR = 3'b001,
      DWID_CMD  = 3'b010,
      DWID_DATA = 3'b011,
      DWID_DONE = 3'b100
   } dwid_state_e;
endpackage : dwid_pkg

// [dwid_sync_if.sv]
// interface carrying the synchronised line samples and detected events
`timescale 1ns/10ps
interface dwid_sync_if;
   logic scl_rise;   // serial clock rising edge, one cycle
   logic scl_fall;   // serial clock falling edge, one cycle
   logic start_det;  // start condition seen, one cycle
   logic stop_det;   // stop condition seen, one cycle
   logic sda;        // synchronised data level
   modport src (output scl_rise, scl_fall, start_det, stop_det, sda);
   modport dst (input scl_rise, scl_fall, start_det, stop_det, sda);
endinterface : dwid_sync_if

// [dwid_line_sync.sv]
// line synchroniser and bus event detector for the two-wire pins
`timescale 1ns/10ps
module dwid_line_sync
   import dwid_pkg::*;
(
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_b_i,
   // raw pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   // events out
   dwid_sync_if.src  ev
);
   logic [1:0] scl_meta_r; // [0] first stage, read only by [1]
   logic [1:0] sda_meta_r;
   logic       scl_q_r;    // delayed copy for edge detection
   logic       sda_q_r;

   // two-stage synchronisers; idle bus is high
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_meta_r <= 2'h3;
         sda_meta_r <= 2'h3;
      end else begin
         scl_meta_r <= {scl_meta_r[0], scl_i};
         sda_meta_r <= {sda_meta_r[0], sda_i};
      end
   end

   // history for edge detection, taken from the second stage only
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_meta_r[1];
         sda_q_r <= sda_meta_r[1];
      end
   end

   // start and stop are data edges while the clock stays high
   assign ev.scl_rise  = scl_meta_r[1] & ~scl_q_r;
   assign ev.scl_fall  = ~scl_meta_r[1] & scl_q_r;
   assign ev.start_det = scl_meta_r[1] & scl_q_r & sda_q_r & ~sda_meta_r[1];
   assign ev.stop_det  = scl_meta_r[1] & scl_q_r & ~sda_q_r & sda_meta_r[1];
   assign ev.sda       = sda_meta_r[1];
endmodule : dwid_line_sync

// [dwid_write_decoder.sv]
// two-wire write-only slave loading two wiper position registers
// Functional notes
// - command byte on clocks 10-17, codes 11h/12h/13h
// - command 11h loads wiper a immediately
// - command 12h loads wiper b immediately
// - command 13h loads both wipers together
// - all eight data bits select tap
// - both wipers start at midscale 80h
// - frame: start, address, command, data, stop
// - address is 0101 plus three select pins
// - high eighth address bit means no-operation
// - acknowledge by holding data low ninth clock
`timescale 1ns/10ps
module dwid_write_decoder
   import dwid_pkg::*;
(
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   // two-wire pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   // address select straps
   input  wire logic       addr_select_pin_0_i,
   input  wire logic       addr_select_pin_1_i,
   input  wire logic       addr_select_pin_2_i,
   // wiper tap indexes
   output logic [7:0]      wiper_a_position_o,
   output logic [7:0]      wiper_b_position_o
);
   // events, frame state and byte decode
   dwid_sync_if ev ();               // synchronised events
   dwid_state_e state_r;             // byte position in frame
   logic [3:0]  bit_cnt_r;           // bit within byte, 8 = ack slot
   logic [7:0]  shift_r;             // incoming byte
   logic [7:0]  cmd_r;               // latched command byte
   // strap synchronisers and address decode helpers
   logic [2:0]  sel_sync_r [2];      // strap synchronisers
   logic [2:0]  sel_r;               // synchronised strap value
   logic        ack_now;             // byte complete and accepted
   logic        ack_pend_r;          // byte accepted, ack slot pending
   logic        addr_match;          // upper seven bits hit this device
   logic        noop_or_write_bit;   // eighth address bit, high = no-op
   logic        addr_ok;             // address matches, write bit low
   logic [7:0]  byte_in;             // byte including last bit

   // pin synchronisers plus start, stop and clock edge events
   dwid_line_sync u_sync (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .ev      (ev)
   );

   // straps come from pins, so two flops before use; a third stage
   // gives a registered copy for the address compare
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_sync_r[0] <= 3'h0;
         sel_sync_r[1] <= 3'h0;
         sel_r         <= 3'h0;
      end else begin
         sel_sync_r[0] <= {addr_select_pin_2_i, addr_select_pin_1_i,
                           addr_select_pin_0_i};
         sel_sync_r[1] <= sel_sync_r[0];
         sel_r         <= sel_sync_r[1];
      end
   end

   // the eighth bit is sampled on the same rising edge that ends the byte,
   // so the address decision needs no extra cycle before the ack slot
   assign byte_in = {shift_r[6:0], ev.sda};

   // fixed upper nibble plus the three straps form the slave address
   assign addr_match = (byte_in[7:1] == {DWID_ADDR_HI, sel_r});

   // reads are not supported, a high eighth bit is a no-operation
   assign noop_or_write_bit = byte_in[0];

   // only a write to this address opens the command byte
   assign addr_ok = addr_match && !noop_or_write_bit;

   // decide on the eighth rising edge whether this byte earns an ack;
   // done and idle bytes are never acked, so extra bytes see a nack
   always_comb begin
      ack_now = 1'b0;
      if (ev.scl_rise && bit_cnt_r == DWID_LAST_DATA) begin
         unique case (state_r)
            DWID_ADDR: ack_now = addr_ok;  // read gets no ack
            // command and data bytes are always acked
            DWID_CMD:  ack_now = 1'b1;
            DWID_DATA: ack_now = 1'b1;
            default:   ack_now = 1'b0;
         endcase
      end
   end

   // bit counter: 0..7 data bits, 8 acknowledge slot; start and stop
   // realign it, so a frame cut short cannot leave it out of step
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_cnt_r <= 4'h0;
      end else if (ev.start_det || ev.stop_det) begin
         bit_cnt_r <= 4'h0;
      end else if (ev.scl_rise) begin
         // count clocks, wrap after the acknowledge slot
         if (bit_cnt_r == DWID_ACK_BIT) begin
            bit_cnt_r <= 4'h0;
         end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
      end
   end

   // shift data in msb first on rising clock edges; the ack slot is
   // skipped, its level is the answer and not data
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         shift_r <= 8'h00;
      end else if (ev.scl_rise && bit_cnt_r != DWID_ACK_BIT) begin
         shift_r <= byte_in;
      end
   end

   // frame sequencer; start anywhere restarts, stop always ends;
   // an unmatched address parks in idle until the next start
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= DWID_IDLE;
      end else if (ev.start_det) begin
         // a start, even in mid byte, opens a new frame
         state_r <= DWID_ADDR;
      end else if (ev.stop_det) begin
         // a stop ends the frame wherever it falls
         state_r <= DWID_IDLE;
      end else if (ev.scl_rise && bit_cnt_r == DWID_LAST_DATA) begin
         unique case (state_r)
            DWID_IDLE: state_r <= DWID_IDLE;
            DWID_ADDR: state_r <= addr_ok ? DWID_CMD : DWID_IDLE;
            DWID_CMD:  state_r <= DWID_DATA;
            // bytes after the data byte are counted but never decoded
            DWID_DATA: state_r <= DWID_DONE; // extra bytes are ignored
            DWID_DONE: state_r <= DWID_DONE;
            default:   state_r <= DWID_IDLE;
         endcase
      end
   end

   // command byte kept until the data byte arrives; unknown codes are
   // kept as well and simply match no wiper below
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_r <= 8'h00;
      end else if (ev.scl_rise && bit_cnt_r == DWID_LAST_DATA
                   && state_r == DWID_CMD) begin
         cmd_r <= byte_in;
      end
   end

   // wiper registers; data lands as soon as the last data bit is in,
   // so a master that skips the final ack still moves the wiper
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // both wipers sit at midscale until the first accepted write
         wiper_a_position_o <= DWID_WIPER_RESET;
         wiper_b_position_o <= DWID_WIPER_RESET;
      end else if (ev.scl_rise && bit_cnt_r == DWID_LAST_DATA
                   && state_r == DWID_DATA) begin
         // one destination per code; the both code writes a and b at once
         unique case (cmd_r)
            DWID_CMD_REG_A:  wiper_a_position_o <= byte_in;
            DWID_CMD_REG_B:  wiper_b_position_o <= byte_in;
            DWID_CMD_REG_AB: begin
               wiper_a_position_o <= byte_in;
               wiper_b_position_o <= byte_in;
            end
            default: ; // unknown command, data dropped
         endcase
      end
   end

   // acknowledge drive: armed on bit 8, pulled low from the falling
   // edge before the ninth clock until the falling edge after it, so the
   // line is stable through the whole high phase; a nacked byte leaves
   // the line to the pull-up
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_oe_o <= 1'b0;
      end else if (ev.start_det || ev.stop_det) begin
         // start or stop in the slot releases the line at once
         sda_oe_o <= 1'b0;
      end else if (ev.scl_fall) begin
         // enable moves only while the clock is low
         sda_oe_o <= (bit_cnt_r == DWID_ACK_BIT) && ack_pend_r;
      end
   end

   // ack pending flag, retaken on every rising edge so it lives only
   // from the eighth clock of a byte to the ninth
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_pend_r <= 1'b0;
      end else if (ev.start_det || ev.stop_det) begin
         // start or stop cancels any pending acknowledge
         ack_pend_r <= 1'b0;
      end else if (ev.scl_rise) begin
         ack_pend_r <= ack_now;
      end
   end

   // open-drain: only ever drives low
   // the line is released by dropping the enable, never driven high
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end
endmodule : dwid_write_decoder

// [dwid_bus_master.sv]
// bus master model that writes frames to the wiper decoder
`timescale 1ns/10ps
module dwid_bus_master (
   // pacing clock and resolved data line in, pins out
   input  wire logic mclk_i,
   input  wire logic sda_i,
   output logic      scl_o = 1'b1,
   output logic      sda_low_o = 1'b0
);
   // quarter of the 320 ns serial period; clock stands high between frames
   task automatic q();
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : q
   // data moves only while the clock is low, sampled mid-high
   task automatic put_bit(input logic b, output logic r);
      sda_low_o = ~b;
      q();
      scl_o = 1'b1;
      q();
      r = sda_i;
      q();
      scl_o = 1'b0;
      q();
   endtask : put_bit
   // start, three bytes each with a released ack slot, stop
   task automatic write(input logic [7:0] a, c, d, output logic [2:0] k);
      logic [23:0] f;
      logic        r;
      f = {a, c, d};
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b0;
      q();
      for (int i = 23; i >= 0; i--) begin
         put_bit(f[i], r);
         if (i % 8 == 0) begin
            put_bit(1'b1, r);
            k[i / 8] = ~r;
         end
      end
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b0;
      repeat (4) q();
   endtask : write
endmodule : dwid_bus_master

// [dwid_write_decoder_asserts.sv]
// pin-level checker of the wiper write decoder
`timescale 1ns/10ps
module dwid_write_decoder_asserts (
   input wire logic       mclk_i,
   input wire logic       rst_b_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic       addr_select_pin_0_i,
   input wire logic       addr_select_pin_1_i,
   input wire logic       addr_select_pin_2_i,
   input wire logic [7:0] wiper_a_position_o,
   input wire logic [7:0] wiper_b_position_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   a_drive_only_low: assert property (sda_o == 1'b0)
      else $error("data drive value not low");
   a_reset_midscale: assert property ($rose(rst_b_i) |->
      wiper_a_position_o == 8'h80 && wiper_b_position_o == 8'h80)
      else $error("wipers not at midscale after reset");
   a_ack_holds_high: assert property (
      sda_oe_o && scl_i |=> sda_oe_o || !scl_i)
      else $error("ack dropped during clock high");
   a_ack_rise_low: assert property (
      $rose(sda_oe_o) |-> !scl_i && $past(scl_i, 5))
      else $error("ack started outside clock low");
   a_ack_fall_low: assert property ($fell(sda_oe_o) |-> !scl_i)
      else $error("ack ended during clock high");
   a_ack_length: assert property (
      $rose(sda_oe_o) |-> sda_oe_o [*6] ##[1:4] !sda_oe_o)
      else $error("ack pulse length wrong");
   a_wiper_a_quiet: assert property (
      !$stable(wiper_a_position_o) |-> !sda_oe_o)
      else $error("wiper a moved during ack");
   a_wiper_b_quiet: assert property (
      !$stable(wiper_b_position_o) |-> !sda_oe_o)
      else $error("wiper b moved during ack");
endmodule : dwid_write_decoder_asserts
bind dwid_write_decoder dwid_write_decoder_asserts dwid_write_decoder_asserts_i (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .addr_select_pin_0_i(addr_select_pin_0_i),
   .addr_select_pin_1_i(addr_select_pin_1_i),
   .addr_select_pin_2_i(addr_select_pin_2_i),
   .wiper_a_position_o(wiper_a_position_o),
   .wiper_b_position_o(wiper_b_position_o));

// [dwid_write_decoder_tb.sv]
// self-checking bench of the wiper write decoder
`timescale 1ns/10ps
module dwid_write_decoder_tb;
   logic       mclk_i = 1'b0;  // system clock
   logic       rst_b_i = 1'b0; // reset, active low
   logic [2:0] strap = 3'h5;   // address straps
   logic       scl, m_low, oe, drv;
   logic [7:0] wa, wb, ea, eb; // wipers seen and expected
   logic [2:0] k;              // acks of the last frame
   wire        sda = ~(m_low | (oe & ~drv)); // pulled-up open drain
   int         err_total = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   dwid_write_decoder dwid_write_decoder_i (.mclk_i(mclk_i),
      .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(drv),
      .sda_oe_o(oe), .addr_select_pin_0_i(strap[0]),
      .addr_select_pin_1_i(strap[1]), .addr_select_pin_2_i(strap[2]),
      .wiper_a_position_o(wa), .wiper_b_position_o(wb));
   dwid_bus_master dwid_bus_master_i (.mclk_i(mclk_i), .sda_i(sda),
      .scl_o(scl), .sda_low_o(m_low));
   initial forever #20 mclk_i = ~mclk_i;
   // hang guard, far above the roughly 1700 cycles needed
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // wait n edges, then step past them so outputs have settled
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : wt
   // reset held 16 cycles, wipers must come up at midscale
   task automatic t_reset();
      rst_b_i = 1'b0;
      wt(16);
      rst_b_i = 1'b1;
      wt(4);
      ea = 8'h80;
      eb = 8'h80;
      chk(wa, ea);
      chk(wb, eb);
   endtask : t_reset
   // one frame, then acks and both wipers compared
   task automatic wr(input logic [7:0] a, c, d, input logic [2:0] ek);
      dwid_bus_master_i.write(a, c, d, k);
      wt(4);
      chk({5'h0, k}, {5'h0, ek});
      chk(wa, ea);
      chk(wb, eb);
   endtask : wr
   // each code in turn with end taps and a mixed pattern
   task automatic t_cmds();
      logic [7:0] dv [3] = '{8'h00, 8'hFF, 8'hA5};
      for (int i = 0; i < 3; i++) begin
         if (i != 1) ea = dv[i];
         if (i != 0) eb = dv[i];
         wr({4'h5, strap, 1'b0}, 8'h11 + 8'(i), dv[i], 3'h7);
      end
   endtask : t_cmds
   // refusals leave the wipers alone; moved straps give a new address
   task automatic t_refuse();
      wr({4'h5, strap, 1'b0}, 8'h14, 8'h3C, 3'h7);
      wr({4'h5, strap, 1'b1}, 8'h11, 8'h3C, 3'h0);
      wr({4'h5, ~strap, 1'b0}, 8'h13, 8'h3C, 3'h0);
      strap = 3'h2;
      wt(8);
      eb = 8'h01;
      wr({4'h5, 3'h2, 1'b0}, 8'h12, 8'h01, 3'h7);
   endtask : t_refuse
   initial begin
      t_reset();
      t_cmds();
      t_refuse();
      t_reset();
      final_report();
   end
endmodule : dwid_write_decoder_tb
